// ==== design/asr_pkg.sv ====
package asr_pkg;

    // Geometry of the memory outside
    localparam int ADDR_W      = 10;
    localparam int DATA_W      = 4;
    localparam int WORDS       = 1024;

    // Clock and pin timing, in ns and in cycles of the system clock
    localparam int CLK_PERIOD_NS      = 10;
    localparam int ADDR_SETUP_NS      = 10;
    localparam int DATA_SETUP_NS      = 5;
    localparam int WRITE_PULSE_NS     = 16;
    localparam int WRITE_HOLD_NS      = 5;
    localparam int ADDR_ACCESS_NS     = 25;
    localparam int ADDR_SETUP_CYC     = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_HOLD_CYC     = (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_WAIT_CYC      = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W              = 3;

    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
    localparam logic [CNT_W-1:0] CNT_ONE  = 3'h1;

    // Pins driven toward the memory
    typedef struct packed {
        logic              sel_n;
        logic              wr_n;
        logic [ADDR_W-1:0] word_addr;
        logic [DATA_W-1:0] write_data_in;
    } asr_pins_t;

    // User request
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asr_req_t;

    localparam asr_pins_t PINS_IDLE = '{sel_n: 1'b1, wr_n: 1'b1, word_addr: '0,
                                        write_data_in: '0};

endpackage

// ==== design/asr_hold.sv ====
`timescale 1ns/1ps
// Down counter that reports when a programmed wait has elapsed
module asr_hold (
    // Clock and reset
    input  wire logic                     i_clk_sys,
    input  wire logic                     i_rst,
    // Control
    input  wire logic                     i_load,
    input  wire logic [asr_pkg::CNT_W-1:0] i_count,
    // Status
    output logic                          o_done
);
    logic [asr_pkg::CNT_W-1:0] cnt_reg;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_reg <= asr_pkg::CNT_ZERO;
        end else if (i_load) begin
            cnt_reg <= i_count;
        end else if (cnt_reg != asr_pkg::CNT_ZERO) begin
            cnt_reg <= cnt_reg - asr_pkg::CNT_ONE;
        end
    end

    // Not gated by load: the caller decodes load from done
    assign o_done = (cnt_reg == asr_pkg::CNT_ZERO);
endmodule

// ==== design/asr_ctrl.sv ====
`timescale 1ns/1ps
// Function
// RULE1: Any of 1024 four-bit words may be read or written.
// RULE2: Controller drives a ten-bit word address; memory decodes it.
// RULE3: Select low with strobe low writes the input data.
// RULE4: Select low with strobe high reads stored word, not inverted.
// RULE5: Memory outputs low when deselected or writing.
// RULE6: Write data stays steady through data set-up plus write pulse.
// RULE7: Write strobe held low at least 16 ns per write.
// RULE8: Deselected memories hold outputs low for wired-OR expansion.
// RULE9: Deselected memory keeps all stored words unchanged.
module asr_ctrl (
    // Clock and reset
    input  wire logic                      i_clk_sys,
    input  wire logic                      i_rst,
    // User request
    input  wire logic                      i_req_valid,
    input  wire asr_pkg::asr_req_t         i_req,
    output logic                           o_req_ready,
    // User answer
    output logic                           o_rsp_valid,
    output logic [asr_pkg::DATA_W-1:0]     o_rsp_data,
    // Memory pins
    output asr_pkg::asr_pins_t             o_pins,
    input  wire logic [asr_pkg::DATA_W-1:0] i_read_data_out
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ
    } asr_state_t;

    asr_state_t                     state_reg;
    asr_state_t                     state_next;
    asr_pkg::asr_pins_t             pins_reg;
    logic                           wr_reg;
    logic                           ready_reg;
    logic                           rsp_valid_reg;
    logic [asr_pkg::DATA_W-1:0]     rsp_data_reg;
    logic                           load;
    logic [asr_pkg::CNT_W-1:0]      load_cnt;
    logic                           done;
    logic                           take;

    assign take = i_req_valid && ready_reg;

    asr_hold u_hold (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_load    (load),
        .i_count   (load_cnt),
        .o_done    (done)
    );

    always_comb begin
        state_next = state_reg;
        load       = 1'b0;
        load_cnt   = asr_pkg::CNT_ZERO;
        case (state_reg)
            ST_IDLE: begin
                if (take) begin
                    state_next = ST_SETUP;
                    load       = 1'b1;
                    load_cnt   = asr_pkg::CNT_W'(asr_pkg::ADDR_SETUP_CYC);
                end
            end
            ST_SETUP: begin
                if (done && wr_reg) begin
                    state_next = ST_STROBE;
                    load       = 1'b1;
                    // RULE7 strobe low time
                    load_cnt   = asr_pkg::CNT_W'(asr_pkg::WRITE_PULSE_CYC);
                end else if (done) begin
                    state_next = ST_READ;
                    load       = 1'b1;
                    load_cnt   = asr_pkg::CNT_W'(asr_pkg::READ_WAIT_CYC);
                end
            end
            ST_STROBE: begin
                if (done) begin
                    state_next = ST_HOLD;
                    load       = 1'b1;
                    load_cnt   = asr_pkg::CNT_W'(asr_pkg::WRITE_HOLD_CYC);
                end
            end
            ST_HOLD: begin
                if (done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_READ: begin
                if (done) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Request capture and handshake
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ready_reg <= 1'b1;
            wr_reg    <= 1'b0;
        end else if (take) begin
            ready_reg <= 1'b0;
            wr_reg    <= i_req.wr;
        end else if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
            ready_reg <= 1'b1;
        end
    end

    // Pin drive
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pins_reg <= asr_pkg::PINS_IDLE;
        end else if (take) begin
            // RULE2: ten-bit address
            pins_reg.word_addr     <= i_req.addr;
            // RULE6: data steady from here
            pins_reg.write_data_in <= i_req.wdata;
            pins_reg.sel_n         <= 1'b0;
            pins_reg.wr_n          <= 1'b1;
        end else if (state_next == ST_STROBE) begin
            // RULE3: write strobe low
            pins_reg.wr_n <= 1'b0;
        end else if (state_next == ST_HOLD) begin
            pins_reg.wr_n <= 1'b1;
        end else if (state_next == ST_IDLE) begin
            // RULE8 RULE9: deselect between accesses
            pins_reg.sel_n <= 1'b1;
            pins_reg.wr_n  <= 1'b1;
        end
    end

    // Read answer
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg  <= '0;
        end else if (state_reg == ST_READ && done) begin
            // RULE4: sample non-inverted read data
            rsp_valid_reg <= 1'b1;
            rsp_data_reg  <= i_read_data_out;
        end else begin
            rsp_valid_reg <= 1'b0;
        end
    end

    assign o_pins      = pins_reg;
    assign o_req_ready = ready_reg;
    assign o_rsp_valid = rsp_valid_reg;
    assign o_rsp_data  = rsp_data_reg;

    // Strobe low-time counter for assertions
    logic [asr_pkg::CNT_W-1:0] low_cnt_reg;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || pins_reg.wr_n) begin
            low_cnt_reg <= asr_pkg::CNT_ZERO;
        end else begin
            low_cnt_reg <= low_cnt_reg + asr_pkg::CNT_ONE;
        end
    end

    // Edges from a taken read to its sampled answer
    localparam int READ_LAT = asr_pkg::ADDR_SETUP_CYC + asr_pkg::READ_WAIT_CYC + 3;

    a_strobe_min_width: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE7
        $rose(pins_reg.wr_n) |-> low_cnt_reg >= asr_pkg::CNT_W'(asr_pkg::WRITE_PULSE_CYC))
        else $error("write strobe too short");
    a_data_stable_write: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE6
        !pins_reg.wr_n |-> $stable(pins_reg.write_data_in) && $stable(pins_reg.word_addr))
        else $error("data moved during write");
    a_strobe_needs_sel: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE3
        !pins_reg.wr_n |-> !pins_reg.sel_n)
        else $error("strobe without select");
    a_addr_before_strobe: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE2
        $fell(pins_reg.wr_n) |-> !$past(pins_reg.sel_n) && $stable(pins_reg.word_addr))
        else $error("address not set up before strobe");
    a_read_answer: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE4
        take && !i_req.wr |-> ##READ_LAT o_rsp_valid)
        else $error("read answer late");
    a_idle_deselect: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE9
        o_req_ready && !$past(take) |-> pins_reg.sel_n && pins_reg.wr_n)
        else $error("memory selected while idle");
    a_write_no_rsp: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE5
        !pins_reg.wr_n |-> !o_rsp_valid)
        else $error("answer during write");
    a_deselect_after: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE8
        o_rsp_valid |-> pins_reg.sel_n)
        else $error("still selected after read");

    // Write phase order and read answer shape
    a_data_setup: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE6
        $fell(pins_reg.wr_n) |-> $past(pins_reg.write_data_in, 2) == pins_reg.write_data_in)
        else $error("write data not set up before strobe");
    a_data_held_rise: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE6
        $rose(pins_reg.wr_n) |-> $stable(pins_reg.write_data_in) && !pins_reg.sel_n)
        else $error("write data or select dropped at strobe end");
    a_addr_held_rise: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE2
        $rose(pins_reg.wr_n) |-> $stable(pins_reg.word_addr))
        else $error("address moved at strobe end");
    a_strobe_ends: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE7
        $fell(pins_reg.wr_n) |-> ##[1:4] pins_reg.wr_n)
        else $error("write strobe stuck low");
    a_strobe_in_phase: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE7
        !pins_reg.wr_n |-> state_reg == ST_STROBE)
        else $error("strobe low outside strobe phase");
    a_busy_not_ready: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE6
        state_reg != ST_IDLE |-> !o_req_ready)
        else $error("ready while an access runs");
    a_read_no_strobe: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE4
        state_reg == ST_READ |-> pins_reg.wr_n && !pins_reg.sel_n)
        else $error("read phase with strobe or no select");
    a_rsp_single: assert property (@(posedge i_clk_sys) disable iff (i_rst) // RULE4
        o_rsp_valid |=> !o_rsp_valid)
        else $error("read answer longer than one cycle");
endmodule

// ==== bench/asr_mem_model.sv ====
`timescale 1ns/1ps
module asr_mem_model (
    // Memory pins
    input  wire asr_pkg::asr_pins_t    i_pins,
    output logic [asr_pkg::DATA_W-1:0] o_read_data_out,
    // Strobe timing fault seen
    output logic                       o_viol
);
    logic [asr_pkg::DATA_W-1:0] mem [asr_pkg::WORDS];
    realtime                    t_low;
    realtime                    t_data;
    initial begin
        o_viol = 1'b0;
        t_low = 0.0;
        t_data = 0.0;
        foreach (mem[i]) mem[i] = 4'h0;
    end
    always @* begin
        if (!i_pins.sel_n && !i_pins.wr_n) begin
            mem[i_pins.word_addr] = i_pins.write_data_in;
        end
    end
    // plain read, low when off or writing
    assign o_read_data_out = (!i_pins.sel_n && i_pins.wr_n) ? mem[i_pins.word_addr] : 4'h0;
    always @(i_pins.write_data_in) t_data = $realtime;
    always @(negedge i_pins.wr_n) t_low = $realtime;
    always @(posedge i_pins.wr_n) begin
        if (t_low > 0.0 && ($realtime - t_low < 16.0 || t_low - t_data < 5.0)) o_viol = 1'b1;
    end
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    logic               clk_sys, rst, req_valid, req_ready, rsp_valid, viol0, viol1;
    logic [3:0]         rsp_data, rd0, rd1;
    asr_pkg::asr_req_t  req;
    asr_pkg::asr_pins_t pins, pins_off;
    int                 miscompares = 0, n_checks = 0, cycles = 0;
    logic [9:0]         adr [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
    logic [3:0]         dat [4] = '{4'ha, 4'h5, 4'hf, 4'h0};

    // Second memory never selected, outputs joined by wired-OR
    assign pins_off = '{sel_n: 1'b1, wr_n: pins.wr_n, word_addr: pins.word_addr,
                        write_data_in: pins.write_data_in};
    asr_ctrl DUT (.i_clk_sys(clk_sys), .i_rst(rst), .i_req_valid(req_valid), .i_req(req),
        .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
        .o_pins(pins), .i_read_data_out(rd0 | rd1));
    asr_mem_model mem0 (.i_pins(pins), .o_read_data_out(rd0), .o_viol(viol0));
    asr_mem_model mem1 (.i_pins(pins_off), .o_read_data_out(rd1), .o_viol(viol1));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic wrap_up;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [9:0] a, input logic [3:0] d,
                        output logic [3:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{wr: wr, addr: a, wdata: d};
        @(posedge clk_sys);
        while (req_ready !== 1'b1 && n < 10) begin
            @(posedge clk_sys);
            n++;
        end
        req_valid <= 1'b0;
        q = 4'h0;
        if (!wr) begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 10) begin
                @(posedge clk_sys);
                n++;
            end
            q = rsp_data;
        end
        chk("wait bound", 16'h0, {15'h0, n >= 10});
    endtask

    task automatic t_fill;
        logic [3:0] q;
        for (int i = 0; i < 4; i++) xfer(1'b1, adr[i], dat[i], q);
        for (int i = 3; i >= 0; i--) begin
            xfer(1'b0, adr[i], 4'h0, q);
            chk("read word", {12'h0, dat[i]}, {12'h0, q});
        end
    endtask

    task automatic t_overwrite;
        logic [3:0] q;
        xfer(1'b1, adr[2], 4'h6, q);
        xfer(1'b0, adr[2], 4'h0, q);
        chk("rewritten word", 16'h6, {12'h0, q});
        xfer(1'b1, adr[1], 4'h9, q);
        @(posedge clk_sys);
        while (req_ready !== 1'b1) @(posedge clk_sys);
        chk("held read data", 16'h6, {12'h0, rsp_data});
        xfer(1'b0, adr[1], 4'h0, q);
        chk("second word", 16'h9, {12'h0, q});
        xfer(1'b0, adr[0], 4'h0, q);
        chk("neighbour word", 16'ha, {12'h0, q});
    endtask

    task automatic t_reset;
        logic [3:0] q;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req <= '{wr: 1'b1, addr: adr[3], wdata: 4'h3};
        @(posedge clk_sys);
        req_valid <= 1'b0;
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk("idle pins", asr_pkg::PINS_IDLE, pins);
        chk("ready after reset", 16'h1, {15'h0, req_ready});
        xfer(1'b0, adr[0], 4'h0, q);
        chk("word after reset", 16'ha, {12'h0, q});
        xfer(1'b0, adr[3], 4'h0, q);
        chk("cut write word", 16'h0, {12'h0, q});
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (!rst && pins.sel_n === 1'b1 && pins.wr_n !== 1'b1) begin
            miscompares++;
            $display("unexpected strobe: expected 1 seen %b", pins.wr_n);
        end
        if (cycles == 3000) begin
            miscompares++;
            wrap_up;
        end
    end

    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req = '0;
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        t_fill;
        t_overwrite;
        t_reset;
        chk("timing faults", 16'h0, {14'h0, viol1, viol0});
        wrap_up;
    end
endmodule
